// [hdl/sar_readout.sv]
// Conversion control and serial result readout of the converter
`timescale 1ns/1ps
// What this block does
// - Serial input low at start selects daisy
// - Serial input high at start selects chip-select
// - Busy option emits one indicator bit first
// - Start rise floats output, samples, converts
// - Conversion ignores start edges once running; start level at its end picks the indicator
// - Conversion length stays within min and max
// - Converter off in acquisition, result readable
// - Serial clock only shifts data out
// - Start fall presents MSB, clock shifts rest
// - Float after sixteenth edge or start rise
// - Busy option drives low, then MSB first
// - Float after seventeenth edge or start rise
// - Result is sixteen-bit unsigned straight binary
module sar_readout (
	// System clock and synchronous reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Serial clock from the host
	input wire logic link_sclk,
	// Host pins
	input wire logic conversion_start,
	input wire logic serial_in,
	// Serial output pin drive
	output adc_pkg::dout_drive_t dout,
	// Converter array interface
	input wire logic [adc_pkg::RESULT_W-1:0] sample_code,
	output logic sample_strobe,
	output logic converter_on,
	// Status flags
	output adc_pkg::adc_status_t status
);

	// Start line synchroniser, first stage, second stage, delayed copy
	logic start_m_q;
	logic start_s_q;
	logic start_d_q;
	// Serial input synchroniser
	logic din_m_q;
	logic din_s_q;
	// Serial clock falling edge toggle, in the link domain
	logic edge_tgl_q = 1'b0;
	// Edge toggle synchroniser and delayed copy, in the system domain
	logic tgl_m_q = 1'b0;
	logic tgl_s_q = 1'b0;
	logic tgl_d_q;
	// Frame sequencer
	adc_pkg::frame_state_t state_q;
	adc_pkg::frame_state_t state_d;
	// Output shift register, top bit drives the pin
	logic [adc_pkg::FRAME_W-1:0] tx_q;
	logic [adc_pkg::FRAME_W-1:0] tx_d;
	// Falling edges counted in the current frame
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	// Pin drive enable
	logic oe_q;
	logic oe_d;
	// Interface option latched per conversion
	logic daisy_q;
	logic daisy_d;
	logic busy_q;
	logic busy_d;
	// Registered sample pulse
	logic strobe_q;
	// Timer end of conversion
	logic conv_done;

	// Edges of the start line and serial clock edge events
	wire start_rise = start_s_q && !start_d_q;
	wire start_fall = !start_s_q && start_d_q;
	wire shift_ev = tgl_s_q ^ tgl_d_q;
	// A new conversion is accepted outside a running conversion
	wire conv_begin = start_rise && (state_q != adc_pkg::ST_CONV);
	// Start low at conversion end asks for the indicator
	wire busy_now = !start_s_q;
	// Edge count after this event and the count that ends the frame
	wire [4:0] cnt_next = cnt_q + adc_pkg::EDGE_CNT_ONE;
	wire [4:0] cnt_last = busy_q ? adc_pkg::EDGES_BUSY : adc_pkg::EDGES_PLAIN;
	// Frame word: indicator ahead of the result, or result with a pad bit
	wire [adc_pkg::FRAME_W-1:0] frame_busy = {adc_pkg::BUSY_BIT, sample_code};
	wire [adc_pkg::FRAME_W-1:0] frame_plain = {sample_code, 1'b0};

	// Conversion duration timer
	conv_timer u_conv_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(conv_begin),
		.done(conv_done)
	);

	// Link domain: each falling serial clock edge flips the toggle
	always_ff @(negedge link_sclk) begin
		edge_tgl_q <= ~edge_tgl_q;
	end

	// Two-stage synchronisers for the pins
	always_ff @(posedge sys_clk) begin
		start_m_q <= conversion_start;
		start_s_q <= start_m_q;
		din_m_q <= serial_in;
		din_s_q <= din_m_q;
	end

	// Two-stage synchroniser for the edge toggle
	always_ff @(posedge sys_clk) begin
		tgl_m_q <= edge_tgl_q;
		tgl_s_q <= tgl_m_q;
	end

	// Delayed copies for edge detection; reset absorbs stale edges
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			start_d_q <= start_s_q;
			tgl_d_q <= tgl_s_q;
		end else begin
			start_d_q <= start_s_q;
			tgl_d_q <= tgl_s_q;
		end
	end

	// Frame sequencer next state
	always_comb begin
		state_d = state_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		oe_d = oe_q;
		daisy_d = daisy_q;
		busy_d = busy_q;
		if (conv_begin) begin
			// New conversion: float, latch option, start timer
			state_d = adc_pkg::ST_CONV;
			oe_d = 1'b0;
			daisy_d = !din_s_q;
			cnt_d = adc_pkg::EDGE_CNT_RST;
		end else begin
			case (state_q)
				// Nothing pending
				adc_pkg::ST_IDLE: begin
					state_d = adc_pkg::ST_IDLE;
				end
				// Converting, start edges have no effect; the start level at conversion end picks the indicator
				adc_pkg::ST_CONV: begin
					if (conv_done) begin
						tx_d = busy_now ? frame_busy : frame_plain;
						busy_d = busy_now;
						cnt_d = adc_pkg::EDGE_CNT_RST;
						if (daisy_q) begin
							state_d = adc_pkg::ST_IDLE;
						end else if (busy_now) begin
							oe_d = 1'b1;
							state_d = adc_pkg::ST_SHIFT;
						end else begin
							state_d = adc_pkg::ST_WAIT;
						end
					end
				end
				// Acquisition, waiting for the select to fall
				adc_pkg::ST_WAIT: begin
					if (start_fall) begin
						oe_d = 1'b1;
						state_d = adc_pkg::ST_SHIFT;
					end
				end
				// Shifting on serial clock falling edges
				adc_pkg::ST_SHIFT: begin
					if (shift_ev) begin
						tx_d = {tx_q[adc_pkg::FRAME_W-2:0], 1'b0};
						cnt_d = cnt_next;
						if (cnt_next == cnt_last) begin
							oe_d = 1'b0;
							state_d = adc_pkg::ST_IDLE;
						end
					end
				end
				// Illegal code recovers to idle
				default: begin
					state_d = adc_pkg::ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// Frame sequencer registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= adc_pkg::ST_IDLE;
			tx_q <= '0;
			cnt_q <= adc_pkg::EDGE_CNT_RST;
			oe_q <= 1'b0;
			daisy_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			oe_q <= oe_d;
			daisy_q <= daisy_d;
			busy_q <= busy_d;
		end
	end

	// Sample pulse marks the moment the input is held
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= conv_begin;
		end
	end

	// Pin drive and status straight from registers
	assign dout.data = tx_q[adc_pkg::FRAME_W-1];
	assign dout.oe = oe_q;
	assign sample_strobe = strobe_q;
	// Converter powered only while converting
	assign converter_on = (state_q == adc_pkg::ST_CONV);
	assign status.converting = (state_q == adc_pkg::ST_CONV);
	assign status.daisy_mode = daisy_q;
	assign status.busy_mode = busy_q;
	assign status.reading = (state_q == adc_pkg::ST_SHIFT);

	// Serial input high at a new start selects chip-select mode
	property p_mode_cs;
		@(posedge sys_clk) disable iff (sys_rst)
		conv_begin && din_s_q |=> !status.daisy_mode;
	endproperty
	a_mode_cs: assert property (p_mode_cs) else $error("chip-select mode not chosen");

	// Serial input low at a new start selects daisy mode, no drive for the eight cycles after
	property p_mode_daisy;
		@(posedge sys_clk) disable iff (sys_rst)
		conv_begin && !din_s_q |=> status.daisy_mode ##1 (!dout.oe)[*8];
	endproperty
	a_mode_daisy: assert property (p_mode_daisy) else $error("daisy mode not chosen");

	// A new start floats the pin and pulses the sample strobe
	property p_start_float;
		@(posedge sys_clk) disable iff (sys_rst)
		conv_begin |=> !dout.oe && sample_strobe && converter_on;
	endproperty
	a_start_float: assert property (p_start_float) else $error("start did not float output");

	// Start edges during a conversion leave it running
	property p_conv_runs;
		@(posedge sys_clk) disable iff (sys_rst)
		converter_on && !conv_done |=> converter_on;
	endproperty
	a_conv_runs: assert property (p_conv_runs) else $error("conversion disturbed");

	// Indicator: low drive at conversion end when the start line is low
	property p_busy_bit;
		@(posedge sys_clk) disable iff (sys_rst)
		converter_on && conv_done && !daisy_q && !start_s_q |=> dout.oe && !dout.data && !converter_on;
	endproperty
	a_busy_bit: assert property (p_busy_bit) else $error("busy indicator missing");

	// No indicator: stay floating until the select falls, then show MSB
	property p_plain_msb;
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == adc_pkg::ST_WAIT) && start_fall |=> dout.oe && (dout.data == $past(tx_q[adc_pkg::FRAME_W-1]));
	endproperty
	a_plain_msb: assert property (p_plain_msb) else $error("MSB not presented on select fall");

	// The pin floats on the last counted edge
	property p_frame_end;
		@(posedge sys_clk) disable iff (sys_rst)
		status.reading && shift_ev && !conv_begin && (cnt_q == (busy_q ? 5'h10 : 5'h0f)) |=> !dout.oe;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("output not floated at frame end");

	// Busy frames run one edge longer than plain frames
	property p_busy_len;
		@(posedge sys_clk) disable iff (sys_rst)
		status.reading && busy_q && shift_ev && !conv_begin && (cnt_q == 5'h0f) |=> dout.oe;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy frame ended early");

	// The captured word is the converter code at conversion end
	property p_load;
		@(posedge sys_clk) disable iff (sys_rst)
		converter_on && conv_done && !conv_begin |=> (tx_q[adc_pkg::FRAME_W-1:1] == $past(sample_code))
			|| (tx_q[adc_pkg::FRAME_W-2:0] == $past(sample_code));
	endproperty
	a_load: assert property (p_load) else $error("result not loaded");

	// The held word only moves on a serial clock edge
	property p_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		status.reading && !shift_ev && !conv_begin |=> $stable(tx_q);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without a clock edge");

endmodule // sar_readout

// [inc/adc_pkg.sv]
// Shared constants, types and timing counts for the converter readout block
package adc_pkg;

	// System clock rate and the period derived from it
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;

	// Conversion time window, in nanoseconds as specified
	localparam int T_CONV_MIN_NS = 500;
	localparam int T_CONV_MAX_NS = 930;

	// Least time rounds up, longest time rounds down
	localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int CONV_MAX_CYC = T_CONV_MAX_NS / SYS_CLK_PERIOD_NS;

	// Width of the conversion timer counters
	localparam int CONV_CNT_W = 5;

	// Conversion length as timer counter values
	localparam logic [CONV_CNT_W-1:0] CONV_MIN_LEN = CONV_CNT_W'(CONV_MIN_CYC);
	localparam logic [CONV_CNT_W-1:0] CONV_ONE = 5'h01;

	// Result word width
	localparam int RESULT_W = 16;

	// Frame word width: one leading indicator or trailing pad bit plus the result
	localparam int FRAME_W = RESULT_W + 1;

	// Falling serial clock edges that end a frame, without and with the indicator
	localparam logic [4:0] EDGES_PLAIN = 5'h10;
	localparam logic [4:0] EDGES_BUSY = 5'h11;
	localparam logic [4:0] EDGE_CNT_RST = 5'h00;
	localparam logic [4:0] EDGE_CNT_ONE = 5'h01;

	// Level driven as the busy indicator bit
	localparam logic BUSY_BIT = 1'b0;

	// Reset value of the length randomiser, nonzero
	localparam logic [7:0] LFSR_SEED = 8'h5a;

	// Frame sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CONV = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_SHIFT = 4'b1000
	} frame_state_t;

	// Serial output pin drive
	typedef struct packed {
		logic data;
		logic oe;
	} dout_drive_t;

	// Status flags seen by the surrounding logic
	typedef struct packed {
		logic converting;
		logic daisy_mode;
		logic busy_mode;
		logic reading;
	} adc_status_t;

endpackage

// [hdl/conv_timer.sv]
// Conversion duration timer with sample-to-sample length variation
`timescale 1ns/1ps
module conv_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Start pulse and end-of-conversion pulse
	input wire logic start,
	output logic done
);

	// Free-running randomiser for the conversion length
	logic [7:0] lfsr_q;
	// Cycle counter and the length chosen for this conversion
	logic [adc_pkg::CONV_CNT_W-1:0] cnt_q;
	logic [adc_pkg::CONV_CNT_W-1:0] len_q;
	// Conversion running
	logic run_q;
	// Extra cycles above the minimum, 0 to 8
	wire [adc_pkg::CONV_CNT_W-1:0] extra = {2'h0, lfsr_q[2:0]} + {4'h0, lfsr_q[3]};
	wire [adc_pkg::CONV_CNT_W-1:0] len_pick = adc_pkg::CONV_MIN_LEN + extra;
	wire lfsr_fb = lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3];

	// End of conversion when the count reaches the chosen length
	assign done = run_q && (cnt_q == len_q);

	// Randomiser steps every cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lfsr_q <= adc_pkg::LFSR_SEED;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_fb};
		end
	end

	// Length is drawn at start and the count runs to it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			run_q <= 1'b0;
			cnt_q <= '0;
			len_q <= adc_pkg::CONV_MIN_LEN;
		end else if (start) begin
			run_q <= 1'b1;
			cnt_q <= adc_pkg::CONV_ONE;
			len_q <= len_pick;
		end else if (done) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q + adc_pkg::CONV_ONE;
		end
	end

	// Done rises 10 to 18 cycles after the start pulse
	property p_conv_len;
		@(posedge sys_clk) disable iff (sys_rst)
		start |=> (!done && !start)[*8] ##1 (!done && !start) ##[1:9] done;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length out of bounds");

endmodule // conv_timer

// [verif/spi_host_model.sv]
// Host side model: drives start, mode pin and serial clock, captures frames
`timescale 1ns/1ps
module spi_host_model (
	// System clock for pin updates
	input wire logic sys_clk,
	// Host pins toward the converter
	output logic link_sclk,
	output logic conversion_start,
	output logic serial_in,
	// Serial output pin as driven by the converter
	input wire logic dout_data,
	input wire logic dout_oe
);
	// Pull-up holds the line high while the converter floats it
	wire logic dout_line = dout_oe ? dout_data : 1'b1;

	// Idle levels; serial clock stands low between frames
	initial begin
		link_sclk = 1'b0;
		conversion_start = 1'b0;
		serial_in = 1'b1;
	end

	// Wait a number of system cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Start a conversion; mode pin picks chip-select or daisy
	task automatic start_conv(input logic mode_cs, input logic busy, input logic noisy);
		@(posedge sys_clk);
		serial_in <= mode_cs;
		cyc(1);
		conversion_start <= 1'b1;
		cyc(4);
		serial_in <= 1'b1;
		// Busy option: low well before the shortest conversion ends
		if (busy) begin
			conversion_start <= 1'b0;
		end
		// One stray serial clock pulse early in the conversion
		if (noisy) begin
			#62.5 link_sclk = 1'b1;
			#62.5 link_sclk = 1'b0;
		end
		// Level held past the longest conversion plus sync delay
		cyc(26);
	endtask

	// Read n bits; each is taken half a period after its falling edge
	task automatic read_frame(input logic busy, input int n, output logic [adc_pkg::FRAME_W-1:0] word);
		word = '0;
		// Without indicator the start fall selects the output
		if (!busy) begin
			conversion_start <= 1'b0;
			cyc(4);
		end
		// Off-grid start keeps serial clock edges clear of system clock edges
		#6.25;
		// Taken at the next rising edge: the previous shift has crossed, this one not yet
		for (int i = 0; i <= n; i++) begin
			#62.5;
			if (i > 0) begin
				word = {word[adc_pkg::FRAME_W-2:0], dout_line};
			end
			if (i < n) begin
				link_sclk = 1'b1;
				#62.5 link_sclk = 1'b0;
			end
		end
		cyc(4);
	endtask
endmodule // spi_host_model

// [verif/test_sar_readout.sv]
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
module test_sar_readout;
	// Clock, reset and design pins
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_sclk;
	logic conversion_start;
	logic serial_in;
	logic [adc_pkg::RESULT_W-1:0] sample_code = 16'h0000;
	adc_pkg::dout_drive_t dout;
	logic sample_strobe;
	logic converter_on;
	adc_pkg::adc_status_t status;
	// Scoreboard state and expected result queue
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int conv_len = 0;
	logic [adc_pkg::RESULT_W-1:0] exp_q[$];
	logic [adc_pkg::FRAME_W-1:0] word;
	logic [adc_pkg::RESULT_W-1:0] exp_w;
	logic busy;

	// System clock, 50 ns period
	always #25 sys_clk = ~sys_clk;

	// Device under test
	sar_readout uut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.link_sclk(link_sclk),
		.conversion_start(conversion_start),
		.serial_in(serial_in),
		.dout(dout),
		.sample_code(sample_code),
		.sample_strobe(sample_strobe),
		.converter_on(converter_on),
		.status(status)
	);

	// Host on the far side
	spi_host_model host (
		.sys_clk(sys_clk),
		.link_sclk(link_sclk),
		.conversion_start(conversion_start),
		.serial_in(serial_in),
		.dout_data(dout.data),
		.dout_oe(dout.oe)
	);

	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Print counts and verdict, then end the run
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// New random converter code, stable until the next call
	task automatic new_code();
		@(posedge sys_clk);
		sample_code <= 16'($urandom());
	endtask

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// Conversion monitor: start response, length, expected result
	always @(posedge sys_clk) begin
		if (!sys_rst && sample_strobe) begin
			check({converter_on, dout.oe}, 2'b10);
		end
		if (converter_on) begin
			conv_len++;
		end else if (conv_len != 0) begin
			check(conv_len >= adc_pkg::CONV_MIN_CYC && conv_len <= adc_pkg::CONV_MAX_CYC, 1'b1);
			exp_q.push_back(sample_code);
			conv_len = 0;
		end
	end

	// Main sequence
	initial begin
		void'($urandom(19200));
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		host.cyc(3);
		// Daisy selection: reported, output stays floating
		new_code();
		host.start_conv(1'b0, 1'b0, 1'b0);
		check({status.daisy_mode, dout.oe}, 2'b10);
		host.read_frame(1'b0, 0, word);
		check(dout.oe, 1'b0);
		exp_w = exp_q.pop_front();
		// Full frames in both chip-select options
		for (int i = 0; i < 8; i++) begin
			busy = i[0];
			new_code();
			host.start_conv(1'b1, busy, i[1]);
			check({status.daisy_mode, status.busy_mode, converter_on, status.converting, status.reading},
				{1'b0, busy, 1'b0, 1'b0, busy});
			check(dout.oe, busy);
			if (busy) begin
				check(dout.data, 1'b0);
			end
			host.read_frame(busy, busy ? 17 : 16, word);
			exp_w = exp_q.pop_front();
			check(word, {1'b0, exp_w});
			check(dout.oe, 1'b0);
		end
		// Partial frame cut short by a new start rise
		new_code();
		host.start_conv(1'b1, 1'b0, 1'b0);
		host.read_frame(1'b0, 5, word);
		exp_w = exp_q.pop_front();
		check({dout.oe, status.reading, word[4:0]}, {1'b1, 1'b1, exp_w[15:11]});
		new_code();
		fork
			host.start_conv(1'b1, 1'b1, 1'b0);
			begin
				host.cyc(8);
				check({dout.oe, converter_on, status.converting, sample_strobe}, 4'b0110);
			end
		join
		host.read_frame(1'b1, 17, word);
		exp_w = exp_q.pop_front();
		check(word, {1'b0, exp_w});
		report_and_stop();
	end
endmodule // test_sar_readout
